// *** rtl/reset_button_boot_selector.sv ***
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Operation
// - status steady green while starting, blinking when ready; power LED on
// - lan yellow while transmitting, lan green while link is up
// - while button held, status and aux LEDs show the hold phase
// - short hold release reboots the active partition
// - 4.5 s to 7.5 s: all LEDs off (only status and aux here; power and lan LEDs keep following inputs); release swaps partition, reboots
// - past 7.5 s: all LEDs on (only status and aux here; power and lan LEDs keep following inputs); release reboots from restore
// - normal boot uses the partition marked active
// - update written to inactive partition, then marked active, reboot
// - ten failed boots on active partition make the other active
// - ten failed boots on both partitions select restore
// - restore partition is never a write target of an update
// - restore boot resets address to default and enables dhcp
// - restore-side install writes both partitions, resets address, login
// - identify lights LEDs for about ten seconds

module reset_button_boot_selector #(
    parameter logic [31:0] HOLD_B_CYC = boot_sel_pkg::HOLD_B_CYC,
    parameter logic [31:0] HOLD_C_CYC = boot_sel_pkg::HOLD_C_CYC,
    parameter logic [31:0] IDENT_CYC  = boot_sel_pkg::IDENT_CYC,
    parameter logic [31:0] BLINK_CYC  = boot_sel_pkg::BLINK_CYC,
    parameter logic [31:0] DEB_CYC    = boot_sel_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // front panel inputs
    input  wire logic        button_n,
    input  wire logic        power_good,
    input  wire logic        lan_link,
    input  wire logic        lan_tx_active,
    // non-volatile boot record, read after reset
    input  wire logic        nv_active,
    input  wire logic [3:0]  nv_fail_a,
    input  wire logic [3:0]  nv_fail_b,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // indicators
    output logic             status_led_green,
    output logic             power_led_green,
    output logic             lan_led_yellow,
    output logic             lan_led_green,
    output logic      [2:0]  auxiliary_indicator_leds,
    // boot control and non-volatile record
    output logic             reboot_req,
    output logic      [1:0]  boot_sel,
    output logic             active_part,
    output logic      [3:0]  fail_a,
    output logic      [3:0]  fail_b,
    output logic             ip_default,
    output logic             dhcp_enable,
    output logic      [1:0]  image_wr_mask,
    output logic             creds_reset
);

    boot_sel_pkg::hold_phase_e phase, next_phase;
    logic        pressed;
    logic [31:0] hold_cnt, next_hold_cnt;
    logic [31:0] blink_cnt, next_blink_cnt;
    logic        blink_on, next_blink_on;
    logic [2:0]  aux_step, next_aux_step;
    logic [31:0] ident_cnt, next_ident_cnt;
    logic        next_status, next_power, next_yellow, next_green;
    logic [2:0]  next_aux;
    logic        loaded, next_loaded;
    logic        start_pend, next_pend;
    logic        rest_req, next_rest_req;
    logic        ready, next_ready;
    logic        next_reboot, next_active, next_creds, next_ipdef;
    logic [1:0]  next_boot_sel, next_mask;
    logic [3:0]  next_fail_a, next_fail_b;
    logic [31:0] next_rdata;
    logic        release_a, release_b, release_c, ctrl_wr, boot_eval;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic at_limit(input logic [3:0] cnt);
        return cnt >= boot_sel_pkg::FAIL_LIMIT;
    endfunction : at_limit

    function automatic boot_sel_pkg::hold_phase_e hold_phase_f(
        input logic [31:0] cnt);
        if (cnt >= HOLD_C_CYC) begin
            return boot_sel_pkg::PH_C;
        end else if (cnt >= HOLD_B_CYC) begin
            return boot_sel_pkg::PH_B;
        end
        return boot_sel_pkg::PH_A;
    endfunction : hold_phase_f

    // ------------------------------------------------------------------
    // button
    // ------------------------------------------------------------------
    button_debounce #(
        .SETTLE_CYC (DEB_CYC)
    ) u_debounce (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .button_n (button_n),
        .pressed  (pressed)
    );

    assign release_a = (phase == boot_sel_pkg::PH_A) && !pressed;
    assign release_b = (phase == boot_sel_pkg::PH_B) && !pressed;
    assign release_c = (phase == boot_sel_pkg::PH_C) && !pressed;
    assign ctrl_wr   = reg_wr && (reg_addr == boot_sel_pkg::REG_CTRL);
    assign boot_eval = loaded && start_pend;

    // hold timer and phase
    always_comb begin
        next_hold_cnt = 32'h0;
        next_phase    = boot_sel_pkg::PH_IDLE;
        if (pressed) begin
            next_hold_cnt = (hold_cnt == 32'hffffffff) ? hold_cnt
                                                        : hold_cnt + 32'h1;
            next_phase    = hold_phase_f(hold_cnt);
        end
    end

    // ------------------------------------------------------------------
    // indicators
    // ------------------------------------------------------------------
    always_comb begin
        next_blink_cnt = blink_cnt + 32'h1;
        next_blink_on  = blink_on;
        next_aux_step  = aux_step;
        if (blink_cnt >= BLINK_CYC - 32'h1) begin
            next_blink_cnt = 32'h0;
            next_blink_on  = !blink_on;
            next_aux_step  = {aux_step[1:0], aux_step[2]};
        end
        next_ident_cnt = (ident_cnt != 32'h0) ? ident_cnt - 32'h1 : 32'h0;
        if (ctrl_wr && reg_wdata[boot_sel_pkg::CTRL_IDENTIFY]) begin
            next_ident_cnt = IDENT_CYC;
        end
        next_power  = power_good;
        next_yellow = lan_tx_active;
        next_green  = lan_link;
        case (phase)
            boot_sel_pkg::PH_A: begin
                next_status = blink_on;
                next_aux    = aux_step;
            end
            boot_sel_pkg::PH_B: begin
                next_status = 1'b0;
                next_aux    = 3'h0;
            end
            boot_sel_pkg::PH_C: begin
                next_status = 1'b1;
                next_aux    = 3'h7;
            end
            default: begin
                next_status = ready ? blink_on : 1'b1;
                next_aux    = (ident_cnt != 32'h0) ? 3'h7 : 3'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase                    <= boot_sel_pkg::PH_IDLE;
            hold_cnt                 <= 32'h0;
            blink_cnt                <= 32'h0;
            blink_on                 <= 1'b0;
            aux_step                 <= 3'h1;
            ident_cnt                <= 32'h0;
            status_led_green         <= 1'b0;
            power_led_green          <= 1'b0;
            lan_led_yellow           <= 1'b0;
            lan_led_green            <= 1'b0;
            auxiliary_indicator_leds <= 3'h0;
        end else begin
            phase                    <= next_phase;
            hold_cnt                 <= next_hold_cnt;
            blink_cnt                <= next_blink_cnt;
            blink_on                 <= next_blink_on;
            aux_step                 <= next_aux_step;
            ident_cnt                <= next_ident_cnt;
            status_led_green         <= next_status;
            power_led_green          <= next_power;
            lan_led_yellow           <= next_yellow;
            lan_led_green            <= next_green;
            auxiliary_indicator_leds <= next_aux;
        end
    end

    // ------------------------------------------------------------------
    // boot selection
    // ------------------------------------------------------------------
    always_comb begin
        next_loaded   = 1'b1;
        next_pend     = start_pend;
        next_rest_req = rest_req;
        next_ready    = ready;
        next_active   = active_part;
        next_fail_a   = fail_a;
        next_fail_b   = fail_b;
        next_boot_sel = boot_sel;
        next_ipdef    = ip_default;
        next_reboot   = 1'b0;
        next_creds    = 1'b0;
        if (!loaded) begin
            next_active = nv_active;
            next_fail_a = nv_fail_a;
            next_fail_b = nv_fail_b;
        end else begin
            if (start_pend) begin
                next_pend     = 1'b0;
                next_rest_req = 1'b0;
                if (rest_req || (at_limit(fail_a) && at_limit(fail_b))) begin
                    next_boot_sel = boot_sel_pkg::BOOT_REST;
                    next_ipdef    = 1'b1;
                end else begin
                    next_ipdef = 1'b0;
                    if (at_limit(active_part ? fail_b : fail_a)) begin
                        next_active = !active_part;
                    end
                    next_boot_sel = next_active ? boot_sel_pkg::BOOT_B
                                                : boot_sel_pkg::BOOT_A;
                    // attempt counts as failed until completion reported
                    if (!next_active && !at_limit(fail_a)) begin
                        next_fail_a = fail_a + 4'h1;
                    end
                    if (next_active && !at_limit(fail_b)) begin
                        next_fail_b = fail_b + 4'h1;
                    end
                end
            end
            if (release_a || release_b || release_c) begin
                next_reboot = 1'b1;
            end
            if (release_b) begin
                next_active = !next_active;
            end
            if (release_c) begin
                next_rest_req = 1'b1;
            end
            if (ctrl_wr) begin
                next_ready = reg_wdata[boot_sel_pkg::CTRL_READY];
                if (reg_wdata[boot_sel_pkg::CTRL_BOOT_DONE]
                        && !start_pend) begin
                    if (boot_sel == boot_sel_pkg::BOOT_A) begin
                        next_fail_a = 4'h0;
                    end
                    if (boot_sel == boot_sel_pkg::BOOT_B) begin
                        next_fail_b = 4'h0;
                    end
                end
                if (reg_wdata[boot_sel_pkg::CTRL_UPDATE] && !ip_default) begin
                    next_active = !next_active;
                    next_reboot = 1'b1;
                end
                if (reg_wdata[boot_sel_pkg::CTRL_INSTALL] && ip_default) begin
                    next_fail_a = 4'h0;
                    next_fail_b = 4'h0;
                    next_creds  = 1'b1;
                end
            end
            if (next_reboot) begin
                next_pend  = 1'b1;
                next_ready = 1'b0;
            end
        end
        // updates go to the inactive side only, both from restore;
        // taken from the next state so the mask never lags a swap
        next_mask = next_ipdef ? 2'h3
                               : (next_active ? 2'h1 : 2'h2);
    end

    // read mux
    always_comb begin
        next_rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                boot_sel_pkg::REG_CTRL:   next_rdata = {30'h0, ready, 1'b0};
                boot_sel_pkg::REG_STATUS: next_rdata = {13'h0,
                    ident_cnt != 32'h0, 4'(phase), fail_b, fail_a,
                    2'h0, ip_default, active_part, boot_sel};
                boot_sel_pkg::REG_TARGET: next_rdata = {30'h0, image_wr_mask};
                default:                  next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            loaded        <= 1'b0;
            start_pend    <= 1'b1;
            rest_req      <= 1'b0;
            ready         <= 1'b0;
            active_part   <= 1'b0;
            fail_a        <= 4'h0;
            fail_b        <= 4'h0;
            boot_sel      <= boot_sel_pkg::BOOT_A;
            ip_default    <= 1'b0;
            dhcp_enable   <= 1'b0;
            reboot_req    <= 1'b0;
            creds_reset   <= 1'b0;
            image_wr_mask <= 2'h2;
            reg_rdata     <= 32'h0;
        end else begin
            loaded        <= next_loaded;
            start_pend    <= next_pend;
            rest_req      <= next_rest_req;
            ready         <= next_ready;
            active_part   <= next_active;
            fail_a        <= next_fail_a;
            fail_b        <= next_fail_b;
            boot_sel      <= next_boot_sel;
            ip_default    <= next_ipdef;
            dhcp_enable   <= next_ipdef;
            reboot_req    <= next_reboot;
            creds_reset   <= next_creds;
            image_wr_mask <= next_mask;
            reg_rdata     <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_short_release: assert property (release_a |=> reboot_req)
        else $error("short release did not reboot");
    a_swap_release: assert property (
        release_b && !ctrl_wr |=> active_part != $past(active_part))
        else $error("phase b release did not swap partition");
    a_restore_release: assert property (
        release_c |=> ##1 boot_sel == boot_sel_pkg::BOOT_REST)
        else $error("phase c release did not select restore");
    a_leds_off_b: assert property (phase == boot_sel_pkg::PH_B
        |=> !status_led_green && auxiliary_indicator_leds == 3'h0)
        else $error("leds not off in phase b");
    a_leds_on_c: assert property (phase == boot_sel_pkg::PH_C
        |=> status_led_green && auxiliary_indicator_leds == 3'h7)
        else $error("leds not on in phase c");
    a_power_led: assert property (power_good |=> power_led_green)
        else $error("power led not following supply");
    a_fallback_other: assert property (boot_eval && !rest_req
        && !release_b && !ctrl_wr
        && at_limit(active_part ? fail_b : fail_a)
        && !at_limit(active_part ? fail_a : fail_b)
        |=> active_part != $past(active_part))
        else $error("failed partition not swapped");
    a_fallback_rest: assert property (
        boot_eval && at_limit(fail_a) && at_limit(fail_b)
        |=> boot_sel == boot_sel_pkg::BOOT_REST ##1 dhcp_enable)
        else $error("restore not selected after both failed");
    a_update_swap: assert property (ctrl_wr && !ip_default
        && reg_wdata[boot_sel_pkg::CTRL_UPDATE] && !release_b
        |=> reboot_req && active_part != $past(active_part))
        else $error("update did not swap and reboot");
    a_restore_safe: assert property (image_wr_mask != 2'h0
        ##0 (ip_default || image_wr_mask != {active_part, !active_part}))
        else $error("write mask targets the active partition");

    c_phase_c: cover property (release_c);
    c_swap: cover property (release_b);
    c_ident: cover property (auxiliary_indicator_leds == 3'h7
        && phase == boot_sel_pkg::PH_IDLE);

endmodule : reset_button_boot_selector

// *** rtl/boot_sel_pkg.sv ***
package boot_sel_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_KHZ     = 200000;  // 200 mhz system clock
    localparam int unsigned HOLD_B_MS   = 4500;    // start of status and aux off phase
    localparam int unsigned HOLD_C_MS   = 7500;    // start of status and aux on phase
    localparam int unsigned IDENT_MS    = 10000;   // identify lighting time
    localparam int unsigned BLINK_MS    = 250;     // blink half period
    localparam int unsigned DEBOUNCE_MS = 10;      // button settle time

    localparam logic [31:0] HOLD_B_CYC   = 32'(64'(HOLD_B_MS) * 64'(CLK_KHZ));
    localparam logic [31:0] HOLD_C_CYC   = 32'(64'(HOLD_C_MS) * 64'(CLK_KHZ));
    localparam logic [31:0] IDENT_CYC    = 32'(64'(IDENT_MS) * 64'(CLK_KHZ));
    localparam logic [31:0] BLINK_CYC    = 32'(64'(BLINK_MS) * 64'(CLK_KHZ));
    localparam logic [31:0] DEBOUNCE_CYC =
        32'(64'(DEBOUNCE_MS) * 64'(CLK_KHZ));

    // ------------------------------------------------------------------
    // boot bookkeeping
    // ------------------------------------------------------------------
    localparam logic [3:0] FAIL_LIMIT = 4'ha;  // consecutive failed boots
    localparam logic [1:0] BOOT_A     = 2'h0;
    localparam logic [1:0] BOOT_B     = 2'h1;
    localparam logic [1:0] BOOT_REST  = 2'h2;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TARGET = 8'h08;

    localparam int CTRL_BOOT_DONE = 0;  // pulse: boot completed
    localparam int CTRL_READY     = 1;  // level: system ready
    localparam int CTRL_IDENTIFY  = 2;  // pulse: identify request
    localparam int CTRL_UPDATE    = 3;  // pulse: update image written
    localparam int CTRL_INSTALL   = 4;  // pulse: restore-side install done

    // ------------------------------------------------------------------
    // hold phases
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_IDLE = 4'h1,
        PH_A    = 4'h2,
        PH_B    = 4'h4,
        PH_C    = 4'h8
    } hold_phase_e;

endpackage : boot_sel_pkg

// *** rtl/button_debounce.sv ***
`timescale 1ns/1ps

module button_debounce #(
    parameter logic [31:0] SETTLE_CYC = boot_sel_pkg::DEBOUNCE_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // raw button, active low
    input  wire logic button_n,
    // clean level
    output logic      pressed
);

    logic        sync_a;
    logic        sync_b;
    logic [31:0] settle;
    logic [31:0] next_settle;
    logic        next_pressed;

    // ------------------------------------------------------------------
    // settle timer
    // ------------------------------------------------------------------
    // restart whenever the synced level agrees with the output
    always_comb begin
        next_pressed = pressed;
        next_settle  = 32'h0;
        if (!sync_b != pressed) begin
            if (settle >= SETTLE_CYC - 32'h1) begin
                next_pressed = !sync_b;
            end else begin
                next_settle = settle + 32'h1;
            end
        end
    end

    // synchroniser chain and registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_a  <= 1'b1;
            sync_b  <= 1'b1;
            settle  <= 32'h0;
            pressed <= 1'b0;
        end else begin
            sync_a  <= button_n;
            sync_b  <= sync_a;
            settle  <= next_settle;
            pressed <= next_pressed;
        end
    end

endmodule : button_debounce

// *** bench/front_panel.sv ***
`timescale 1ns/1ps

module front_panel (
    // clock
    input  wire logic clk,
    // press request from the bench
    input  wire logic hold,
    // button contact, pulled up when open
    output logic      button_n
);
    logic [1:0] bounce;
    logic       was;

    initial begin
        button_n = 1'b1;
        bounce   = 2'h0;
        was      = 1'b0;
    end

    // contact chatters a few cycles on press, idles high
    always @(posedge clk) begin
        was <= hold;
        if (hold && !was) begin
            bounce <= 2'h3;
        end else if (bounce != 2'h0) begin
            bounce <= bounce - 2'h1;
        end
        button_n <= hold ? ((bounce != 2'h0) ? ~button_n : 1'b0) : 1'b1;
    end
endmodule : front_panel

// *** bench/reset_button_boot_selector_bench.sv ***
`timescale 1ns/1ps

module reset_button_boot_selector_bench;
    logic        clk, sys_rst, hold, button_n, power_good, lan_link, lan_tx;
    logic        nv_active, reg_wr, reg_rd, reboot_req, active_part;
    logic        status_g, power_g, lan_y, lan_g, ip_default, dhcp, creds;
    logic [3:0]  nv_fail_a, nv_fail_b, fail_a, fail_b;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [2:0]  aux;
    logic [1:0]  boot_sel, mask;
    int          mismatches, n_compared, rb, cr, cyc;

    front_panel FP (.clk(clk), .hold(hold), .button_n(button_n));

    reset_button_boot_selector #(.HOLD_B_CYC(32'd40), .HOLD_C_CYC(32'd80),
        .IDENT_CYC(32'd50), .BLINK_CYC(32'd4), .DEB_CYC(32'd3)) DUT (
        .clk(clk), .sys_rst(sys_rst), .button_n(button_n),
        .power_good(power_good), .lan_link(lan_link),
        .lan_tx_active(lan_tx), .nv_active(nv_active),
        .nv_fail_a(nv_fail_a), .nv_fail_b(nv_fail_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .status_led_green(status_g),
        .power_led_green(power_g), .lan_led_yellow(lan_y),
        .lan_led_green(lan_g), .auxiliary_indicator_leds(aux),
        .reboot_req(reboot_req), .boot_sel(boot_sel),
        .active_part(active_part), .fail_a(fail_a), .fail_b(fail_b),
        .ip_default(ip_default), .dhcp_enable(dhcp), .image_wr_mask(mask),
        .creds_reset(creds));

    // 200 mhz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // pulse counters and hang guard
    always @(posedge clk) begin
        if (reboot_req === 1'b1) rb <= rb + 1;
        if (creds === 1'b1) cr <= cr + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic rst(input logic a, input logic [3:0] fa, fb);
        @(posedge clk);
        nv_active <= a;
        nv_fail_a <= fa;
        nv_fail_b <= fb;
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : rst

    // hold the button n cycles, snapshot leds, release and settle
    task automatic press(input int n, output logic [3:0] leds);
        @(posedge clk);
        hold <= 1'b1;
        repeat (n) @(posedge clk);
        #1 leds = {status_g, aux};
        hold <= 1'b0;
        repeat (20) @(posedge clk);
    endtask : press

    task automatic close_out;
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    logic [3:0] l;
    int         r0;
    initial begin
        {sys_rst, hold, reg_wr, reg_rd, lan_link, lan_tx} = 6'h20;
        {nv_active, nv_fail_a, nv_fail_b} = 9'h000;
        {reg_addr, reg_wdata} = 40'h0;
        power_good = 1'b1;
        {mismatches, n_compared, rb, cr, cyc} = 0;
        rst(1'b0, 4'h0, 4'h0);
        chk({power_g, status_g}, 2'h3);
        rd(8'h04, d); chk(d, 32'h4040);
        rd(8'h08, d); chk(d, 32'h2);
        rd(8'h0c, d); chk(d, 32'h0);
        @(posedge clk);
        lan_tx <= 1'b1;
        repeat (3) @(posedge clk);
        chk({lan_y, lan_g}, 2'h2);
        {lan_tx, lan_link} <= 2'h1;
        repeat (3) @(posedge clk);
        chk({lan_y, lan_g}, 2'h1);
        wr(8'h00, 32'h1);
        rd(8'h04, d); chk(d, 32'h4000);
        wr(8'h00, 32'h2);
        rd(8'h00, d); chk(d, 32'h2);
        d[0] = status_g;
        #20 chk(status_g, !d[0]);
        wr(8'h00, 32'h4);
        repeat (10) @(posedge clk);
        chk(aux, 3'h7);
        repeat (50) @(posedge clk);
        chk(aux, 3'h0);
        r0 = rb;
        press(20, l);
        chk(rb - r0, 1); chk(active_part, 1'b0);
        chk($onehot(l[2:0]), 1'b1);
        wr(8'h00, 32'h8);
        repeat (10) @(posedge clk);
        chk({active_part, mask}, 3'h5);
        press(60, l);
        chk(l, 4'h0); chk(boot_sel, 2'h0);
        press(100, l);
        chk(l, 4'hf);
        chk({boot_sel, ip_default, dhcp}, 4'hb);
        wr(8'h00, 32'h10);
        chk(cr, 1);
        chk(mask, 2'h3);
        rst(1'b0, 4'ha, 4'h0); chk(boot_sel, 2'h1);
        rst(1'b1, 4'h0, 4'ha); chk(boot_sel, 2'h0);
        rst(1'b0, 4'ha, 4'ha); chk(boot_sel, 2'h2);
        close_out();
    end
endmodule : reset_button_boot_selector_bench
